// ### core/bc_seq_pkg.sv
// constants shared by the sequencing engine and its call stack
// assumes a single clock domain and 16-bit shared memory words
package bc_seq_pkg;

   // =========================================
   // widths and reset values
   localparam int ADDR_W = 16;
   localparam int STACK_DEPTH = 4;
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [7:0] FLAGS_RST = 8'h00;

   // =========================================
   // op code word layout
   localparam int PARITY_BIT = 15;
   localparam int OP_MSB = 14;
   localparam int OP_LSB = 10;
   localparam int PAT_MSB = 9;
   localparam int PAT_LSB = 5;
   localparam int SENSE_BIT = 4;
   localparam logic [4:0] OPWORD_PATTERN = 5'h0a;

   // =========================================
   // operation codes
   localparam logic [4:0] OP_EXEC_MSG = 5'h01;
   localparam logic [4:0] OP_BRANCH = 5'h02;
   localparam logic [4:0] OP_CALL = 5'h03;
   localparam logic [4:0] OP_RETURN = 5'h04;
   localparam logic [4:0] OP_IRQ = 5'h06;
   localparam logic [4:0] OP_STOP = 5'h07;
   localparam logic [4:0] OP_CFT = 5'h0a;
   localparam logic [4:0] OP_CMT = 5'h0b;
   localparam logic [4:0] OP_FLAG = 5'h0c;
   // arbitrary code, the real value is not known here
   localparam logic [4:0] OP_EXEC_FLIP = 5'h0e;

   // =========================================
   // instruction list and message block offsets
   localparam logic [15:0] ENTRY_STEP = 16'h0002;
   localparam logic [15:0] PRM_OFS = 16'h0001;
   localparam logic [15:0] BLK_CTRL_OFS = 16'h0000;
   localparam logic [15:0] BLK_TTNM_OFS = 16'h0001;
   localparam logic [15:0] BLK_DPTR_OFS = 16'h0002;
   localparam logic [15:0] BLK_CMD_OFS = 16'h0003;
   localparam logic [15:0] BLK_CMD2_OFS = 16'h0008;
   localparam logic [15:0] BLK_STS2_OFS = 16'h0009;
   localparam int BLK_LEN = 8;
   localparam int BLK_LEN_RTRT = 16;

   // =========================================
   // engine states, gray along fetch and message path
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_FETCH_OP = 3'h1,
      S_FETCH_PRM = 3'h3,
      S_EXEC = 3'h2,
      S_MSG_CTRL = 3'h6,
      S_MSG_DPTR = 3'h7,
      S_MSG_WAIT = 3'h5
   } state_e;

endpackage : bc_seq_pkg

// ### core/bc_sequence_engine.sv
// instruction fetch, decode and conditional execution for the bc sequencer
// assumes a memory that answers a held read with a one-cycle ack,
// and a protocol engine that reports each message end with a done pulse
module bc_sequence_engine #(
   parameter int ADDR_W = bc_seq_pkg::ADDR_W,
   parameter int STACK_DEPTH = bc_seq_pkg::STACK_DEPTH
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [15:0] i_init_ptr,
   output logic [15:0] o_ptr,
   output logic o_running,
   output logic o_opword_err,
   input wire logic i_gp_wr,
   input wire logic [15:0] i_gp_data,
   output logic [15:0] o_cond_flags,
   output logic o_mem_rd,
   output logic [15:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic [15:0] i_mem_rdata,
   output logic o_msg_start,
   output logic [15:0] o_msg_blk_addr,
   output logic [15:0] o_msg_ctrl,
   output logic [15:0] o_msg_data_ptr,
   output logic [15:0] o_msg_cmd2_addr,
   input wire logic i_msg_done,
   input wire logic [7:0] i_msg_result,
   input wire logic [15:0] i_frame_time,
   input wire logic [15:0] i_msg_time,
   output logic [3:0] o_user_irq
);
   import bc_seq_pkg::*;

   if (ADDR_W != 16) begin : g_addr_chk
      $error("engine supports a 16-bit address only");
   end
   if (STACK_DEPTH < 1 || STACK_DEPTH > 8) begin : g_depth_chk
      $error("stack depth out of range");
   end

   // =========================================
   // decode helpers
   function automatic logic word_ok(input logic [15:0] w);
      return (^w) && (w[PAT_MSB:PAT_LSB] == OPWORD_PATTERN);
   endfunction : word_ok

   // per flag: {hi,lo} 00 keep, 01 set, 10 clear, 11 toggle
   function automatic logic [7:0] apply_gp(input logic [7:0] f, input logic [15:0] ctl);
      logic [7:0] r;
      r = f;
      for (int i = 0; i < 8; i++) begin
         case ({ctl[i+8], ctl[i]})
            2'b01: r[i] = 1'b1;
            2'b10: r[i] = 1'b0;
            2'b11: r[i] = ~f[i];
            default: r[i] = f[i];
         endcase
      end
      return r;
   endfunction : apply_gp

   // =========================================
   // state and registers
   state_e state_ff, nxt_state;
   logic [15:0] ptr_ff, nxt_ptr, mem_addr_ff, nxt_mem_addr;
   logic mem_rd_ff, nxt_mem_rd, msg_start_ff, err_ff, running_ff;
   logic [15:0] opword_ff, prm_ff, blk_ff, ctrl_ff, dptr_ff, cmd2_ff;
   logic [3:0] irq_ff;
   logic [7:0] gp_ff, nxt_gp, msg_flags_ff;
   logic push, pop, msg_go, stk_full, stk_empty;
   logic [15:0] stk_top;

   logic ack, ok, uncond, go, in_exec;
   logic [4:0] op;
   logic [15:0] flags, next_entry;

   assign ack = mem_rd_ff && i_mem_ack;
   assign op = opword_ff[OP_MSB:OP_LSB];
   assign flags = {msg_flags_ff, gp_ff};
   assign ok = word_ok(opword_ff);
   assign uncond = (op == OP_CFT) || (op == OP_CMT) || (op == OP_FLAG) || (op == OP_EXEC_FLIP);
   assign go = uncond || (flags[opword_ff[3:0]] == opword_ff[SENSE_BIT]);
   assign next_entry = ptr_ff + ENTRY_STEP;
   assign in_exec = (state_ff == S_EXEC) && ok;

   call_stack #(.DEPTH(STACK_DEPTH), .W(16)) u_stack (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_push(push),
      .i_push_data(next_entry),
      .i_pop(pop),
      .o_top(stk_top),
      .o_full(stk_full),
      .o_empty(stk_empty)
   );

   // =========================================
   // sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_ptr = ptr_ff;
      nxt_mem_rd = mem_rd_ff && !i_mem_ack;
      nxt_mem_addr = mem_addr_ff;
      push = 1'b0;
      pop = 1'b0;
      msg_go = 1'b0;
      case (state_ff)
         S_IDLE: begin
            if (i_start) begin
               nxt_ptr = i_init_ptr;
               nxt_state = S_FETCH_OP;
               nxt_mem_rd = 1'b1;
               nxt_mem_addr = i_init_ptr;
            end
         end
         S_FETCH_OP: begin
            if (ack) begin
               nxt_state = S_FETCH_PRM;
               nxt_mem_rd = 1'b1;
               nxt_mem_addr = ptr_ff + PRM_OFS;
            end
         end
         S_FETCH_PRM: begin
            if (ack) begin
               nxt_state = S_EXEC;
            end
         end
         S_EXEC: begin
            nxt_state = S_FETCH_OP;
            nxt_ptr = next_entry;
            if (!ok) begin
               nxt_state = S_IDLE;
               nxt_ptr = ptr_ff;
            end else if (go) begin
               case (op)
                  OP_EXEC_MSG, OP_EXEC_FLIP: begin
                     nxt_state = S_MSG_CTRL;
                     nxt_ptr = ptr_ff;
                     nxt_mem_rd = 1'b1;
                     nxt_mem_addr = prm_ff | BLK_CTRL_OFS;
                  end
                  OP_BRANCH: nxt_ptr = prm_ff;
                  OP_CALL: begin
                     if (!stk_full) begin
                        push = 1'b1;
                        nxt_ptr = prm_ff;
                     end
                  end
                  OP_RETURN: begin
                     if (!stk_empty) begin
                        pop = 1'b1;
                        nxt_ptr = stk_top;
                     end
                  end
                  OP_STOP: begin
                     nxt_state = S_IDLE;
                     nxt_ptr = ptr_ff;
                  end
                  default: nxt_ptr = next_entry;
               endcase
            end
            if (nxt_state == S_FETCH_OP) begin
               nxt_mem_rd = 1'b1;
               nxt_mem_addr = nxt_ptr;
            end
         end
         S_MSG_CTRL: begin
            if (ack) begin
               nxt_state = S_MSG_DPTR;
               nxt_mem_rd = 1'b1;
               nxt_mem_addr = blk_ff | BLK_DPTR_OFS;
            end
         end
         S_MSG_DPTR: begin
            if (ack) begin
               nxt_state = S_MSG_WAIT;
               msg_go = 1'b1;
            end
         end
         S_MSG_WAIT: begin
            if (i_msg_done) begin
               nxt_state = S_FETCH_OP;
               nxt_ptr = next_entry;
               nxt_mem_rd = 1'b1;
               nxt_mem_addr = next_entry;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= S_IDLE;
         ptr_ff <= PTR_RST;
         running_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ptr_ff <= nxt_ptr;
         running_ff <= (nxt_state != S_IDLE);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_rd_ff <= 1'b0;
         mem_addr_ff <= PTR_RST;
      end else begin
         mem_rd_ff <= nxt_mem_rd;
         mem_addr_ff <= nxt_mem_addr;
      end
   end

   // =========================================
   // captured words
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         opword_ff <= 16'h0000;
         prm_ff <= 16'h0000;
         blk_ff <= 16'h0000;
         ctrl_ff <= 16'h0000;
         dptr_ff <= 16'h0000;
         cmd2_ff <= 16'h0000;
      end else begin
         if (state_ff == S_FETCH_OP && ack) begin
            opword_ff <= i_mem_rdata;
         end
         if (state_ff == S_FETCH_PRM && ack) begin
            prm_ff <= i_mem_rdata;
         end
         if (nxt_state == S_MSG_CTRL && state_ff == S_EXEC) begin
            blk_ff <= prm_ff;
            cmd2_ff <= prm_ff | BLK_CMD2_OFS;
         end
         if (state_ff == S_MSG_CTRL && ack) begin
            ctrl_ff <= i_mem_rdata;
         end
         if (state_ff == S_MSG_DPTR && ack) begin
            dptr_ff <= i_mem_rdata;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         msg_start_ff <= 1'b0;
         irq_ff <= 4'h0;
         err_ff <= 1'b0;
      end else begin
         msg_start_ff <= msg_go;
         irq_ff <= (in_exec && go && op == OP_IRQ) ? prm_ff[3:0] : 4'h0;
         if (state_ff == S_IDLE && i_start) begin
            err_ff <= 1'b0;
         end else if (state_ff == S_EXEC && !ok) begin
            err_ff <= 1'b1;
         end
      end
   end

   // =========================================
   // condition flags
   always_comb begin
      nxt_gp = gp_ff;
      if (in_exec && op == OP_FLAG) begin
         nxt_gp = apply_gp(gp_ff, prm_ff);
      end else if (in_exec && op == OP_CFT) begin
         nxt_gp[0] = i_frame_time < prm_ff;
         nxt_gp[1] = i_frame_time == prm_ff;
      end else if (in_exec && op == OP_CMT) begin
         nxt_gp[0] = i_msg_time < prm_ff;
         nxt_gp[1] = i_msg_time == prm_ff;
      end
      if (i_gp_wr) begin
         nxt_gp = apply_gp(nxt_gp, i_gp_data);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gp_ff <= FLAGS_RST;
         msg_flags_ff <= FLAGS_RST;
      end else begin
         gp_ff <= nxt_gp;
         if (state_ff == S_MSG_WAIT && i_msg_done) begin
            msg_flags_ff <= i_msg_result;
         end
      end
   end

   // =========================================
   // outputs
   assign o_ptr = ptr_ff;
   assign o_running = running_ff;
   assign o_opword_err = err_ff;
   assign o_cond_flags = flags;
   assign o_mem_rd = mem_rd_ff;
   assign o_mem_addr = mem_addr_ff;
   assign o_msg_start = msg_start_ff;
   assign o_msg_blk_addr = blk_ff;
   assign o_msg_ctrl = ctrl_ff;
   assign o_msg_data_ptr = dptr_ff;
   assign o_msg_cmd2_addr = cmd2_ff;
   assign o_user_irq = irq_ff;

   // =========================================
   // checks
   start_load_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      state_ff == S_IDLE && i_start |=> o_ptr == $past(i_init_ptr) && o_mem_rd && o_mem_addr == o_ptr)
      else $error("start did not load the pointer");
   param_fetch_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      state_ff == S_FETCH_OP && ack |=> o_mem_rd && o_mem_addr == o_ptr + PRM_OFS)
      else $error("parameter word not fetched after op word");
   bad_word_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      state_ff == S_EXEC && !ok |=> !o_running && o_opword_err && $stable(o_ptr) && !o_msg_start)
      else $error("bad op code word was executed");
   skip_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      in_exec && !go |=> o_ptr == $past(ptr_ff) + ENTRY_STEP && $stable(o_cond_flags[15:8]))
      else $error("failed condition did not skip");
   branch_load_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      in_exec && go && op == OP_BRANCH |=> o_ptr == $past(prm_ff))
      else $error("branch target not loaded");
   irq_pattern_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_user_irq != 4'h0 |-> $past(in_exec && go && op == OP_IRQ) && o_user_irq == $past(prm_ff[3:0]))
      else $error("user interrupt without its instruction");
   stop_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      in_exec && go && op == OP_STOP ##1 !i_start |=> !o_running)
      else $error("stop did not hold the engine");
   msg_launch_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      state_ff == S_MSG_DPTR && ack |=> o_msg_start && o_msg_data_ptr == $past(i_mem_rdata) ##1 !o_msg_start)
      else $error("message start or data pointer wrong");
   msg_flags_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      state_ff == S_MSG_WAIT && i_msg_done |=> o_cond_flags[15:8] == $past(i_msg_result))
      else $error("message flags not updated");
   cft_flags_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      in_exec && op == OP_CFT && !i_gp_wr |=>
         o_cond_flags[1] == ($past(i_frame_time) == $past(prm_ff)) && o_cond_flags[7:2] == $past(gp_ff[7:2]))
      else $error("frame compare flags wrong");

endmodule : bc_sequence_engine

// ### core/call_stack.sv
// return address stack for subroutine calls
// assumes push and pop are never asked in the same cycle
module call_stack #(
   parameter int DEPTH = bc_seq_pkg::STACK_DEPTH,
   parameter int W = bc_seq_pkg::ADDR_W
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_push,
   input wire logic [W-1:0] i_push_data,
   input wire logic i_pop,
   output logic [W-1:0] o_top,
   output logic o_full,
   output logic o_empty
);
   import bc_seq_pkg::*;

   if (DEPTH < 1 || DEPTH > 8) begin : g_depth_chk
      $error("call_stack depth out of range");
   end

   logic [W-1:0] entry_ff [DEPTH];
   logic [3:0] count_ff;

   // =========================================
   // shift stack, entry 0 is the top
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            entry_ff[i] <= '0;
         end
      end else if (i_push && !o_full) begin
         entry_ff[0] <= i_push_data;
         for (int i = 1; i < DEPTH; i++) begin
            entry_ff[i] <= entry_ff[i-1];
         end
      end else if (i_pop && !o_empty) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            entry_ff[i] <= entry_ff[i+1];
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_ff <= 4'h0;
      end else if (i_push && !o_full) begin
         count_ff <= count_ff + 4'h1;
      end else if (i_pop && !o_empty) begin
         count_ff <= count_ff - 4'h1;
      end
   end

   assign o_top = entry_ff[0];
   assign o_full = (count_ff == 4'(DEPTH));
   assign o_empty = (count_ff == 4'h0);

endmodule : call_stack

// ### testbench/mem_model.sv
// partner: shared message memory and a stand-in protocol engine
// assumes the engine holds each read until ack; one clock domain
module mem_model (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_mem_rd,
   input wire logic [15:0] i_mem_addr,
   output logic o_mem_ack,
   output logic [15:0] o_mem_rdata,
   input wire logic i_msg_start,
   output logic o_msg_done,
   input wire logic [1:0] i_lat,
   output logic [7:0] o_msg_cnt
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [0:255];
   logic [1:0] wait_ff;
   logic [2:0] msg_wait_ff;
   logic msg_busy_ff;

   // =========================================
   // reads: ack after i_lat idle cycles, data scrambled when not acked
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_ack <= 1'b0;
         wait_ff <= 2'h0;
         o_mem_rdata <= 16'h5a5a;
      end else if (i_mem_rd && !o_mem_ack && wait_ff == i_lat) begin
         o_mem_ack <= 1'b1;
         o_mem_rdata <= mem[i_mem_addr[7:0]];
         wait_ff <= 2'h0;
      end else begin
         o_mem_ack <= 1'b0;
         o_mem_rdata <= ~o_mem_rdata;
         if (i_mem_rd && !o_mem_ack) begin
            wait_ff <= wait_ff + 2'h1;
         end
      end
   end

   // =========================================
   // message: done pulse some cycles after launch
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         msg_busy_ff <= 1'b0;
         msg_wait_ff <= 3'h0;
         o_msg_done <= 1'b0;
         o_msg_cnt <= 8'h00;
      end else begin
         o_msg_done <= 1'b0;
         if (i_msg_start) begin
            msg_busy_ff <= 1'b1;
            msg_wait_ff <= {1'b0, i_lat} + 3'h1;
            o_msg_cnt <= o_msg_cnt + 8'h01;
         end else if (msg_busy_ff && msg_wait_ff == 3'h0) begin
            msg_busy_ff <= 1'b0;
            o_msg_done <= 1'b1;
         end else if (msg_busy_ff) begin
            msg_wait_ff <= msg_wait_ff - 3'h1;
         end
      end
   end
endmodule : mem_model

// ### testbench/tb_top.sv
// self-checking bench for the sequencing engine
// assumes mem_model as memory and protocol engine stand-in
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bc_seq_pkg::*;

   logic i_mclk = 1'b0, i_rst_n, i_start, i_gp_wr, i_msg_done, i_mem_ack, o_msg_start;
   logic o_running, o_opword_err, o_mem_rd;
   logic [15:0] i_init_ptr, i_gp_data, i_mem_rdata, i_frame_time, i_msg_time, o_ptr, o_cond_flags, o_mem_addr;
   logic [15:0] o_msg_blk_addr, o_msg_ctrl, o_msg_data_ptr, o_msg_cmd2_addr;
   logic [7:0] i_msg_result, msg_cnt;
   logic [3:0] o_user_irq;
   logic [3:0] irq_seen = 4'h0;
   logic [1:0] lat;
   int fail_count, checks;

   always #20 i_mclk = ~i_mclk;

   bc_sequence_engine uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_start(i_start), .i_init_ptr(i_init_ptr),
      .o_ptr(o_ptr), .o_running(o_running), .o_opword_err(o_opword_err), .i_gp_wr(i_gp_wr),
      .i_gp_data(i_gp_data), .o_cond_flags(o_cond_flags), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
      .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_msg_start(o_msg_start),
      .o_msg_blk_addr(o_msg_blk_addr), .o_msg_ctrl(o_msg_ctrl), .o_msg_data_ptr(o_msg_data_ptr),
      .o_msg_cmd2_addr(o_msg_cmd2_addr), .i_msg_done(i_msg_done), .i_msg_result(i_msg_result),
      .i_frame_time(i_frame_time), .i_msg_time(i_msg_time), .o_user_irq(o_user_irq));

   mem_model mem_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
      .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata), .i_msg_start(o_msg_start), .o_msg_done(i_msg_done),
      .i_lat(lat), .o_msg_cnt(msg_cnt));

   always @(posedge i_mclk) if (o_user_irq !== 4'h0) irq_seen <= irq_seen | o_user_irq;

   // =========================================
   // helpers
   function automatic logic [15:0] mk(input logic [4:0] op, input logic [4:0] cond);
      logic [14:0] body;
      body = {op, OPWORD_PATTERN, cond};
      return {~^body, body};
   endfunction : mk

   task automatic put(input logic [15:0] a, input logic [4:0] op, input logic [4:0] cond, input logic [15:0] p);
      mem_i.mem[a[7:0]] = mk(op, cond);
      mem_i.mem[a[7:0] + 8'h01] = p;
   endtask : put

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic run(input logic [15:0] p);
      int n;
      i_init_ptr <= p;
      i_start <= 1'b1;
      @(posedge i_mclk);
      i_start <= 1'b0;
      n = 0;
      @(posedge i_mclk);
      while (o_running === 1'b1 && n < 500) begin
         @(posedge i_mclk);
         n++;
      end
      if (n >= 500) begin
         fail_count++;
         $display("Error at %0t: run did not stop %h %h", $time, o_ptr, 16'h0);
      end
   endtask : run

   task automatic gp(input logic [15:0] d, input logic [15:0] exp);
      i_gp_wr <= 1'b1;
      i_gp_data <= d;
      @(posedge i_mclk);
      i_gp_wr <= 1'b0;
      @(posedge i_mclk);
      chk(o_cond_flags, exp);
   endtask : gp

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   // =========================================
   // scenarios
   task automatic t_reset;
      chk(o_ptr, PTR_RST);
      chk(o_cond_flags, 16'h0000);
      chk({15'h0, o_running}, 16'h0000);
   endtask : t_reset

   task automatic t_host_flags;
      gp(16'h00ff, 16'h00ff);
      gp(16'h0f0f, 16'h00f0);
      gp(16'hf000, 16'h0000);
   endtask : t_host_flags

   task automatic t_flags_branch;
      put(16'h0010, OP_FLAG, 5'h15, 16'h0084);
      put(16'h0012, OP_CFT, 5'h15, 16'h0100);
      put(16'h0014, OP_CMT, 5'h15, 16'h0040);
      put(16'h0016, OP_BRANCH, 5'h12, 16'h0030);
      put(16'h0030, OP_BRANCH, 5'h07, 16'h0010);
      put(16'h0032, OP_STOP, 5'h00, 16'h0000);
      run(16'h0010);
      chk(o_cond_flags, 16'h0086);
      chk(o_cond_flags, 16'h0086);
      chk(o_cond_flags, 16'h0086);
      chk(o_ptr, 16'h0032);
      chk(o_ptr, 16'h0032);
      chk(o_ptr, 16'h0032);
   endtask : t_flags_branch

   task automatic t_message;
      lat <= 2'h2;
      i_msg_result <= 8'h81;
      mem_i.mem[8'h40] = 16'h1234;
      mem_i.mem[8'h42] = 16'h0080;
      put(16'h0050, OP_EXEC_MSG, 5'h12, 16'h0040);
      put(16'h0052, OP_EXEC_MSG, 5'h08, 16'h0040);
      put(16'h0054, OP_STOP, 5'h10, 16'h0000);
      put(16'h0056, OP_EXEC_FLIP, 5'h10, 16'h0040);
      put(16'h0058, OP_STOP, 5'h09, 16'h0000);
      run(16'h0050);
      chk({8'h00, msg_cnt}, 16'h0002);
      chk({8'h00, msg_cnt}, 16'h0002);
      chk(o_msg_blk_addr, 16'h0040);
      chk(o_msg_ctrl, 16'h1234);
      chk(o_msg_data_ptr, 16'h0080);
      chk(o_msg_cmd2_addr, 16'h0048);
      chk(o_cond_flags, 16'h8186);
      chk(o_ptr, 16'h0058);
   endtask : t_message

   task automatic t_call_irq;
      lat <= 2'h0;
      put(16'h0070, OP_CALL, 5'h12, 16'h0090);
      put(16'h0072, OP_STOP, 5'h09, 16'h0000);
      put(16'h0090, OP_IRQ, 5'h12, 16'hfff5);
      put(16'h0092, OP_IRQ, 5'h12, 16'h0010);
      put(16'h0094, OP_RETURN, 5'h12, 16'h0000);
      run(16'h0070);
      chk({12'h000, irq_seen}, 16'h0005);
      chk(o_ptr, 16'h0072);
      chk(o_ptr, 16'h0072);
      chk(o_ptr, 16'h0072);
   endtask : t_call_irq

   task automatic t_parity;
      mem_i.mem[8'ha0] = mk(OP_BRANCH, 5'h12) ^ 16'h8000;
      mem_i.mem[8'ha1] = 16'h0010;
      run(16'h00a0);
      chk({15'h0, o_opword_err}, 16'h0001);
      chk(o_ptr, 16'h00a0);
      run(16'h0072);
      chk({15'h0, o_opword_err}, 16'h0000);
      chk(o_ptr, 16'h0072);
   endtask : t_parity

   // =========================================
   // main sequence and watchdog
   initial begin
      i_rst_n = 1'b0;
      i_start = 1'b0;
      i_init_ptr = 16'h0000;
      i_gp_wr = 1'b0;
      i_gp_data = 16'h0000;
      i_msg_result = 8'h00;
      i_frame_time = 16'h00ff;
      i_msg_time = 16'h0040;
      lat = 2'h0;
      fail_count = 0;
      checks = 0;
      repeat (5) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      t_reset();
      t_host_flags();
      t_flags_branch();
      t_message();
      t_call_irq();
      t_parity();
      report_and_stop();
   end

   initial begin
      #(4000 * 40);
      fail_count++;
      report_and_stop();
   end
endmodule : tb_top
